// >>> design/sls_map.vh
`ifndef SLS_MAP_VH
`define SLS_MAP_VH

// Register byte offsets.
`define SLS_LOOP_CONTROL_REG 4'h0
`define SLS_LOOP_STATUS_REG  4'h4
`define SLS_LINE_STATUS_REG  4'h8
`define SLS_TX_DATA_REG      4'hc

// Loop control fields.
`define SLS_CTL_ABORT_UNDERRUN 0
`define SLS_CTL_LOOP_SELECT    1
`define SLS_CTL_NRZI           2
`define SLS_CTL_MARK_IDLE      3
`define SLS_CTL_ARM            4
`define SLS_CTL_EXT_IE         5
`define SLS_CTL_RESET          6'h00

// Loop status fields.
`define SLS_STA_ON_LOOP      1
`define SLS_STA_LOOP_SENDING 4

// Line status fields.
`define SLS_LIN_TX_EMPTY 2
`define SLS_LIN_HUNT     4
`define SLS_LIN_ONES_RUN 7

// Serial constants.
`define SLS_FLAG      8'h7e
`define SLS_ONES_RUN  3'd6
`define SLS_STUFF_RUN 3'd4
`define SLS_BYTE_BITS 4'd8

// AXI responses.
`define SLS_RESP_OKAY   2'b00
`define SLS_RESP_SLVERR 2'b10

`endif

// >>> design/sls_loop_station.v
// How it works
// - Host sets loop select (control bit 1) after SDLC setup is complete.
// - On loop select, transmit follows receive directly; a flag waits preloaded.
// - With arm set, seven ones set the ones-run flag and insert one-bit delay.
// - Inserting the delay sets on-loop and puts the receiver in hunt.
// - Status bit 1 is on-loop, bit 4 loop-sending; control bit 1 select, 4 arm.
// - After going on loop, sending needs a flag, then another end-of-poll.
// - End-of-poll sets the ones-run flag; interrupt only when enabled.
// - Armed end-of-poll: last one becomes zero, then a flag, then host data.
// - Armed end-of-poll sets ones-run, hunt and loop-sending.
// - Data ready early gives one flag; otherwise flags repeat until data arrives.
// - Arm cleared before last byte: single closing flag, then back to repeating.
// - Loop-sending clears once the closing flag is completely out.
// - Arm still set at frame end: flags until more data or arm cleared.
// - Closing flag then repeating; its last zero plus marking line forms end-of-poll.
// - Select cleared: finish message and close, then disconnect at once.
// - Leave loop on next end-of-poll, or at once in hunt; clear on-loop.
// - NRZI: add a zero after the closing flag if line levels would differ.
// - Underrun and idle settings are ignored while looping.
// - Received bits are watched on receive clock; own data leaves on transmit clock.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "sls_map.vh"

module sls_loop_station (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        rx_data,
	input  wire        rx_clk,
	input  wire        tx_clk,
	output reg         tx_data,
	output reg         ext_status_irq
);

	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_PASS = 3'd1;
	localparam [2:0] ST_HUNT = 3'd2;
	localparam [2:0] ST_READY = 3'd3;
	localparam [2:0] ST_SEND = 3'd4;
	localparam [2:0] ST_TAIL = 3'd5;
	localparam [2:0] ST_EXIT = 3'd6;

	reg [2:0] state;
	reg [5:0] loop_control_reg;
	reg       on_loop;
	reg       loop_sending;
	reg       ones_run_seen;
	reg       hunt;
	reg [7:0] tx_buf;
	reg       tx_full;
	reg [2:0] rxd_sync;
	reg [2:0] rxc_sync;
	reg [2:0] txc_sync;
	reg       rx_prev;
	reg [2:0] rx_ones;
	reg [7:0] rx_shift;
	reg [7:0] tx_shift;
	reg [3:0] tx_cnt;
	reg       tx_is_flag;
	reg       tx_closing;
	reg       tx_ins;
	reg [2:0] tx_ones;
	reg       aw_got;
	reg       w_got;
	reg [3:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;

	wire loop_select = loop_control_reg[`SLS_CTL_LOOP_SELECT];
	wire nrzi        = loop_control_reg[`SLS_CTL_NRZI];
	wire mark_idle   = loop_control_reg[`SLS_CTL_MARK_IDLE];
	wire arm         = loop_control_reg[`SLS_CTL_ARM];
	wire ext_ie      = loop_control_reg[`SLS_CTL_EXT_IE];

	// Edges are found on the second and third stages; the first only feeds the second.
	wire rx_tick = rxc_sync[1] & ~rxc_sync[2];
	wire tx_tick = txc_sync[1] & ~txc_sync[2];
	wire rx_lvl  = rxd_sync[1];

	// Under NRZI a one is an unchanged line level.
	wire rx_bit = nrzi ? (rx_lvl == rx_prev) : rx_lvl;
	wire seven  = rx_tick & rx_bit & (rx_ones == `SLS_ONES_RUN);
	wire flag_in = rx_tick & ({rx_bit, rx_shift[7:1]} == `SLS_FLAG);

	// The bit that the transmitter shifts out on this edge.
	wire tx_bit = tx_ins ? 1'b0 : tx_shift[0];
	wire tx_last = ~tx_ins & (tx_cnt == 4'd1);

	// A register write that lands this cycle.
	wire wr_go = aw_got & w_got & ~s_axi_bvalid;
	wire wr_ctl = wr_go & (aw_addr == `SLS_LOOP_CONTROL_REG) & w_strb[0];
	wire wr_lin = wr_go & (aw_addr == `SLS_LINE_STATUS_REG) & w_strb[0];
	wire wr_txd = wr_go & (aw_addr == `SLS_TX_DATA_REG) & w_strb[0];
	wire wr_ok = (aw_addr == `SLS_LOOP_CONTROL_REG) | (aw_addr == `SLS_LOOP_STATUS_REG) |
	             (aw_addr == `SLS_LINE_STATUS_REG) | (aw_addr == `SLS_TX_DATA_REG);

	// Next line level for a data bit, NRZI turning a zero into a transition.
	function enc;
		input b;
		input nz;
		input cur;
		begin
			enc = nz ? (b ? cur : ~cur) : b;
		end
	endfunction

	// Pin synchronisers and receive bit tracking on the receive clock.
	always @(posedge aclk) begin
		if (!aresetn) begin
			rxd_sync <= 3'b111;
			rxc_sync <= 3'b000;
			txc_sync <= 3'b000;
			rx_prev  <= 1'b1;
			rx_ones  <= 3'd0;
			rx_shift <= 8'h00;
		end else begin
			rxd_sync <= {rxd_sync[1:0], rx_data};
			rxc_sync <= {rxc_sync[1:0], rx_clk};
			txc_sync <= {txc_sync[1:0], tx_clk};
			if (rx_tick) begin
				rx_prev  <= rx_lvl;
				rx_shift <= {rx_bit, rx_shift[7:1]};
				if (!rx_bit)
					rx_ones <= 3'd0;
				else if (rx_ones != 3'd7)
					rx_ones <= rx_ones + 3'd1;
			end
		end
	end

	// Loop sequencing, line mux and transmitter.
	always @(posedge aclk) begin
		if (!aresetn) begin
			state        <= ST_IDLE;
			on_loop      <= 1'b0;
			loop_sending <= 1'b0;
			hunt         <= 1'b0;
			tx_data      <= 1'b1;
			tx_shift     <= `SLS_FLAG;
			tx_cnt       <= `SLS_BYTE_BITS;
			tx_is_flag   <= 1'b1;
			tx_closing   <= 1'b0;
			tx_ins       <= 1'b0;
			tx_ones      <= 3'd0;
		end else begin
			// The receiver leaves hunt once a flag comes in.
			if (flag_in)
				hunt <= 1'b0;
			case (state)
			ST_IDLE: begin
				// Plain SDLC idle: mark, or flags from the transmitter.
				if (mark_idle)
					tx_data <= 1'b1;
				if (loop_select) begin
					state      <= ST_PASS;
					tx_shift   <= `SLS_FLAG;
					tx_cnt     <= `SLS_BYTE_BITS;
					tx_is_flag <= 1'b1;
					tx_ins     <= 1'b0;
				end
			end
			ST_PASS: begin
				// Straight copy; the sampling flops are the only delay here.
				tx_data <= rx_lvl;
				if (!loop_select)
					state <= ST_IDLE;
				else if (arm & seven) begin
					state   <= ST_HUNT;
					on_loop <= 1'b1;
					hunt    <= 1'b1;
					tx_data <= rx_lvl;
				end
			end
			ST_HUNT, ST_READY, ST_EXIT: begin
				// The line flop is the only delay stage; a second one would make it two bits.
				if (rx_tick)
					tx_data <= rx_lvl;
				if (state == ST_HUNT && flag_in)
					state <= ST_READY;
				if (!loop_select && state != ST_EXIT) begin
					// No message under way: leave at once if hunting, else wait in exit for an end-of-poll.
					if (hunt & ~flag_in) begin
						state   <= ST_IDLE;
						on_loop <= 1'b0;
					end else
						state <= ST_EXIT;
				end else if (state == ST_EXIT && seven) begin
					state   <= ST_IDLE;
					on_loop <= 1'b0;
					hunt    <= 1'b1;
				end else if (state == ST_READY && seven) begin
					hunt <= 1'b1;
					if (arm) begin
						// The seventh one goes out as a zero, completing a flag.
						tx_data      <= nrzi ? ~tx_data : 1'b0;
						state        <= ST_SEND;
						loop_sending <= 1'b1;
						tx_shift     <= `SLS_FLAG;
						tx_cnt       <= `SLS_BYTE_BITS;
						tx_is_flag   <= 1'b1;
						tx_closing   <= 1'b0;
						tx_ins       <= 1'b0;
						tx_ones      <= 3'd0;
					end else
						state <= ST_HUNT;
				end
			end
			ST_SEND: begin
				// The transmitter below owns the line and ends the frame.
			end
			ST_TAIL: begin
				if (tx_tick) begin
					// A shared zero that would leave the pins unequal gets a partner.
					if (nrzi && tx_data != rx_lvl)
						tx_data <= ~tx_data;
					state <= loop_select ? ST_READY : ST_IDLE;
					if (!loop_select)
						on_loop <= 1'b0;
				end
			end
			default: state <= ST_IDLE;
			endcase

			// Transmitter runs while sending, or for flag idle outside the loop.
			if (tx_tick && (state == ST_SEND || (state == ST_IDLE && !mark_idle && !loop_select))) begin
				tx_data <= enc(tx_bit, nrzi & (state == ST_SEND), tx_data);
				if (tx_ins) begin
					tx_ins  <= 1'b0;
					tx_ones <= 3'd0;
				end else begin
					// Five ones inside data call for a stuffed zero.
					if (!tx_is_flag && tx_bit) begin
						tx_ones <= tx_ones + 3'd1;
						if (tx_ones == `SLS_STUFF_RUN)
							tx_ins <= 1'b1;
					end else
						tx_ones <= 3'd0;
					if (!tx_last) begin
						tx_shift <= {1'b0, tx_shift[7:1]};
						tx_cnt   <= tx_cnt - 4'd1;
					end
				end
				if (tx_last) begin
					tx_cnt <= `SLS_BYTE_BITS;
					if (state != ST_SEND) begin
						tx_shift   <= `SLS_FLAG;
						tx_is_flag <= 1'b1;
					end else if (tx_closing) begin
						// Closing flag is fully out; underrun and idle bits play no part.
						state        <= ST_TAIL;
						loop_sending <= 1'b0;
						tx_closing   <= 1'b0;
					end else if (tx_full) begin
						tx_shift   <= tx_buf;
						tx_is_flag <= 1'b0;
					end else begin
						tx_shift   <= `SLS_FLAG;
						tx_is_flag <= 1'b1;
						tx_closing <= ~(arm & loop_select);
					end
				end
			end
		end
	end

	// Software-visible flags and the transmit holding byte.
	always @(posedge aclk) begin
		if (!aresetn) begin
			loop_control_reg <= `SLS_CTL_RESET;
			ones_run_seen    <= 1'b0;
			tx_buf           <= 8'h00;
			tx_full          <= 1'b0;
			ext_status_irq   <= 1'b0;
		end else begin
			if (wr_ctl)
				loop_control_reg <= w_data[5:0];
			// A run of seven ones outside idle wins over a clear in the same cycle.
			if (seven && state != ST_IDLE)
				ones_run_seen <= 1'b1;
			else if (wr_lin && w_data[`SLS_LIN_ONES_RUN])
				ones_run_seen <= 1'b0;
			ext_status_irq <= ones_run_seen & ext_ie;
			if (wr_txd) begin
				tx_buf  <= w_data[7:0];
				tx_full <= 1'b1;
			end else if (tx_tick && tx_last && state == ST_SEND && !tx_closing)
				tx_full <= 1'b0;
		end
	end

	// AXI4-Lite write channel: address and data taken in either order.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SLS_RESP_OKAY;
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr       <= 4'h0;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
		end else begin
			s_axi_awready <= ~aw_got & ~s_axi_awready;
			s_axi_wready  <= ~w_got & ~s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got        <= 1'b1;
				aw_addr       <= {s_axi_awaddr[3:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got        <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `SLS_RESP_OKAY : `SLS_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel; data is sampled at the address handshake.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `SLS_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `SLS_RESP_OKAY;
				s_axi_rdata   <= 32'h00000000;
				case ({s_axi_araddr[3:2], 2'b00})
				`SLS_LOOP_CONTROL_REG: s_axi_rdata[5:0] <= loop_control_reg;
				`SLS_LOOP_STATUS_REG: begin
					s_axi_rdata[`SLS_STA_ON_LOOP]      <= on_loop;
					s_axi_rdata[`SLS_STA_LOOP_SENDING] <= loop_sending;
				end
				`SLS_LINE_STATUS_REG: begin
					s_axi_rdata[`SLS_LIN_ONES_RUN] <= ones_run_seen;
					s_axi_rdata[`SLS_LIN_HUNT]     <= hunt;
					s_axi_rdata[`SLS_LIN_TX_EMPTY] <= ~tx_full;
				end
				`SLS_TX_DATA_REG: s_axi_rdata[7:0] <= tx_buf;
				default: s_axi_rresp <= `SLS_RESP_SLVERR;
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule // sls_loop_station
`default_nettype wire

// >>> tb/sls_loop_checker.sv
`timescale 1ns/1ns
`default_nettype none
module sls_loop_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_data,
	input wire logic rx_clk,
	input wire logic tx_clk,
	input wire logic tx_data,
	input wire logic ext_status_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [3:0] quiet;

	// Counts calm cycles on the link and bus, since either may move the line.
	always_ff @(posedge aclk) begin
		if (!aresetn || $changed(rx_data) || $changed(rx_clk) || $changed(tx_clk) || s_axi_wvalid)
			quiet <= 4'h0;
		else if (quiet != 4'hf)
			quiet <= quiet + 4'h1;
	end

	// Bus answers and refusals.
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("late write answer");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read answer");
	a_b_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
	a_r_drops: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
	a_no_new_ar: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	a_no_new_aw: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
	a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready not a pulse");
	// The line only moves after a link edge or a write, so a calm link and bus must hold it still.
	a_tx_quiet: assert property (quiet > 4'h6 |-> $stable(tx_data)) else $error("line moved without cause");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_irq: cover property ($rose(ext_status_irq));
endmodule // sls_loop_checker
bind sls_loop_station sls_loop_checker i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.rx_data, .rx_clk, .tx_clk, .tx_data, .ext_status_irq);
`default_nettype wire

// >>> tb/sls_loop_peer.sv
`timescale 1ns/1ns
`default_nettype none
module sls_loop_peer (
	output logic      rx_clk,
	output logic      rx_data,
	output wire logic tx_clk,
	input  wire logic tx_data
);
	logic [63:0] seen;

	// Both serial clocks come from the loop, so they share one source.
	assign tx_clk = rx_clk;

	// The loop marks high and the clock stands still between polls.
	initial begin
		rx_clk = 1'b0;
		rx_data = 1'b1;
		seen = 64'h0;
	end

	// The downstream station samples the line, newest bit on top.
	always @(posedge rx_clk) seen <= {tx_data, seen[63:1]};

	// Sends bits first-to-last from bit 0, off the bench clock phase.
	task automatic send(input logic [31:0] v, input int n);
		#5;
		for (int i = 0; i < n; i++) begin
			rx_data = v[i];
			#80 rx_clk = 1'b1;
			#80 rx_clk = 1'b0;
		end
		rx_data = 1'b1; // Marking line after the frame.
	endtask
endmodule // sls_loop_peer
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sls_map.vh"
module tb_top;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, v;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        rx_data, rx_clk, tx_clk, tx_data, ext_status_irq;
	int          miscompares = 0, n_compared = 0;

	always #10 aclk = ~aclk;

	sls_loop_station i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_data,
		.rx_clk, .tx_clk, .tx_data, .ext_status_irq);
	sls_loop_peer i_peer (.rx_clk, .rx_data, .tx_clk, .tx_data);

	// Comparison with count; an unknown matches only an identical unknown.
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Write cycle: both channels offered, each released once taken.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	// Read cycle; data and response taken at the rvalid edge.
	task automatic rg(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	// A link frame, then back onto the bench clock phase.
	task automatic lnk(input logic [31:0] b, input int n);
		i_peer.send(b, n);
		@(posedge aclk);
	endtask

	function automatic logic [31:0] sta(input logic on, input logic snd);
		sta = 32'h0;
		sta[`SLS_STA_ON_LOOP] = on;
		sta[`SLS_STA_LOOP_SENDING] = snd;
	endfunction

	function automatic logic has_flag(input logic [63:0] s);
		has_flag = 1'b0;
		for (int i = 0; i < 57; i++) if (s[i+:8] === `SLS_FLAG) has_flag = 1'b1;
	endfunction

	task close_out;
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Cuts a hang short; the whole run needs about 24 us.
	initial begin
		#200000;
		miscompares++;
		close_out();
	end

	// Main sequence; random link data is masked so it never holds more than three ones in a row.
	initial begin
		void'($urandom(86914));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rg(`SLS_LOOP_CONTROL_REG); ck(rd, 32'h0);
		rg(`SLS_LOOP_STATUS_REG); ck(rd, sta(0, 0));
		// Low address bits are dropped, so this lands on the read-only status word.
		wr(4'h6, 32'h12); ck(resp, `SLS_RESP_OKAY);
		rg(`SLS_LOOP_STATUS_REG); ck(rd, sta(0, 0));
		repeat (4) begin
			v = $urandom & 32'h2d;
			wr(`SLS_LOOP_CONTROL_REG, v);
			rg(`SLS_LOOP_CONTROL_REG); ck(rd, v);
			ck(resp, `SLS_RESP_OKAY);
		end
		$display("test registers done");
		wr(`SLS_LOOP_CONTROL_REG, 32'h02);
		v = $urandom & 32'h7777;
		lnk(v, 16); ck(i_peer.seen[63:48], v[15:0]);
		$display("test pass-through done");
		wr(`SLS_LOOP_CONTROL_REG, 32'h32);
		lnk(32'hff, 8);
		rg(`SLS_LOOP_STATUS_REG); ck(rd, sta(1, 0));
		rg(`SLS_LINE_STATUS_REG); ck(rd & 32'h90, 32'h90);
		ck(ext_status_irq, 1'b1);
		wr(`SLS_LINE_STATUS_REG, 32'h80); ck(ext_status_irq, 1'b0);
		v = $urandom & 32'h7777;
		lnk(v, 16); ck(i_peer.seen[63:49], v[14:0]);
		lnk(32'hff, 8);
		rg(`SLS_LOOP_STATUS_REG); ck(rd, sta(1, 0));
		$display("test going on loop done");
		lnk(32'h7f7e, 15);
		rg(`SLS_LOOP_STATUS_REG); ck(rd, sta(1, 1));
		rg(`SLS_LINE_STATUS_REG); ck(rd & 32'h90, 32'h90);
		lnk(32'hffff, 16); ck(has_flag(i_peer.seen), 1'b1);
		wr(`SLS_LOOP_CONTROL_REG, 32'h22);
		wr(`SLS_TX_DATA_REG, $urandom & 32'hff);
		lnk(32'hffffffff, 32);
		rg(`SLS_LOOP_STATUS_REG); ck(rd, sta(1, 0));
		// The closing flag still sits in the newest samples; let eight echoed marks pass.
		lnk(32'hff, 8);
		ck(i_peer.seen[63:56], 8'hff);
		$display("test frame done");
		wr(`SLS_LOOP_CONTROL_REG, 32'h08);
		lnk(32'hff, 8);
		rg(`SLS_LOOP_STATUS_REG); ck(rd, sta(0, 0));
		// The ones-run flag is still set, but the interrupt is now disabled.
		rg(`SLS_LINE_STATUS_REG); ck(rd & 32'h80, 32'h80);
		ck(ext_status_irq, 1'b0);
		$display("test exit done");
		close_out();
	end
endmodule // tb_top
`default_nettype wire
